// >>> sync_ts.sv
// Purpose: sysref capture, lmfc and divider alignment, sample timestamping
// Assumes: frame clock equals clk_i; samples arrive one per clock per channel
// Notes:   register port is a simple strobe interface, read data one cycle later
`timescale 1ns/100ps
module sync_ts #(
  parameter int DIV_RATIO = 4,
  parameter int DIV_W     = 3
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // register access
  input  wire logic [11:0]              reg_addr_i,
  input  wire logic [7:0]               reg_wdata_i,
  input  wire logic                     reg_wr_i,
  output logic      [7:0]               reg_rdata_o,
  // system reference pin
  input  wire logic                     sysref_i,
  // transport and chip configuration
  input  wire logic [7:0]               octets_per_frame_i,
  input  wire logic [5:0]               frames_per_multi_i,
  input  wire logic                     decimation_on_i,
  // window monitor detectors
  input  wire logic [3:0]               setup_status_i,
  input  wire logic [3:0]               hold_status_i,
  // sample path
  input  wire logic [1:0][sync_ts_pkg::SAMPLE_W-1:0] sample_i,
  output sync_ts_pkg::sample_word_s [1:0]            word_o,
  // clock alignment
  output logic                          lmfc_o,
  output logic                          divider_sync_o,
  output logic                          realign_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] capture_ctrl_q, capture_ctrl_d;
  logic [7:0] ts_delay_q, ts_delay_d;
  logic [7:0] monitor_q, monitor_d;
  logic [7:0] chip_sync_q, chip_sync_d;
  logic [7:0] fn_low_q, fn_low_d;
  logic [7:0] fn_high_q, fn_high_d;
  logic [7:0] lmfc_off_q, lmfc_off_d;
  logic [7:0] cs_q, cs_d;
  logic [7:0] subclass_q, subclass_d;
  logic [7:0] rdata_d;
  logic       event_w;

  // register writes; n-shot mode clears itself once the event is taken
  always_comb
  begin
    capture_ctrl_d = capture_ctrl_q;
    ts_delay_d     = ts_delay_q;
    chip_sync_d    = chip_sync_q;
    fn_low_d       = fn_low_q;
    fn_high_d      = fn_high_q;
    lmfc_off_d     = lmfc_off_q;
    cs_d           = cs_q;
    subclass_d     = subclass_q;
    monitor_d      = monitor_q;
    if (event_w && capture_ctrl_q[sync_ts_pkg::MODE_LSB +: 2] == sync_ts_pkg::MODE_NSHOT)
    begin
      capture_ctrl_d[sync_ts_pkg::MODE_LSB +: 2] = sync_ts_pkg::MODE_OFF;
    end
    if (event_w)
    begin
      monitor_d[sync_ts_pkg::HOLD_LSB +: 4]  = hold_status_i;
      monitor_d[sync_ts_pkg::SETUP_LSB +: 4] = setup_status_i;
    end
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        sync_ts_pkg::ADDR_CAPTURE_CTRL: capture_ctrl_d = reg_wdata_i;
        sync_ts_pkg::ADDR_TS_DELAY:     ts_delay_d     = reg_wdata_i;
        sync_ts_pkg::ADDR_CHIP_SYNC:    chip_sync_d    = reg_wdata_i;
        sync_ts_pkg::ADDR_CTRL_FN_LOW:  fn_low_d       = reg_wdata_i;
        sync_ts_pkg::ADDR_CTRL_FN_HIGH: fn_high_d      = reg_wdata_i;
        sync_ts_pkg::ADDR_LMFC_OFFSET:  lmfc_off_d     = reg_wdata_i;
        sync_ts_pkg::ADDR_CTRL_PER_SMP: cs_d           = reg_wdata_i;
        sync_ts_pkg::ADDR_SUBCLASS:     subclass_d     = reg_wdata_i;
        default:                        capture_ctrl_d = capture_ctrl_d;
      endcase
    end
  end

  // register read mux, unmapped addresses read zero
  always_comb
  begin
    case (reg_addr_i)
      sync_ts_pkg::ADDR_CAPTURE_CTRL: rdata_d = capture_ctrl_q;
      sync_ts_pkg::ADDR_TS_DELAY:     rdata_d = ts_delay_q;
      sync_ts_pkg::ADDR_SH_MONITOR:   rdata_d = monitor_q;
      sync_ts_pkg::ADDR_CHIP_SYNC:    rdata_d = chip_sync_q;
      sync_ts_pkg::ADDR_CTRL_FN_LOW:  rdata_d = fn_low_q;
      sync_ts_pkg::ADDR_CTRL_FN_HIGH: rdata_d = fn_high_q;
      sync_ts_pkg::ADDR_LMFC_OFFSET:  rdata_d = lmfc_off_q;
      sync_ts_pkg::ADDR_CTRL_PER_SMP: rdata_d = cs_q;
      sync_ts_pkg::ADDR_SUBCLASS:     rdata_d = subclass_q;
      default:                        rdata_d = 8'h00;
    endcase
  end

  // register state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      capture_ctrl_q <= sync_ts_pkg::RST_ZERO;
      ts_delay_q     <= sync_ts_pkg::RST_ZERO;
      monitor_q      <= sync_ts_pkg::RST_ZERO;
      chip_sync_q    <= sync_ts_pkg::RST_CHIP_SYNC;
      fn_low_q       <= sync_ts_pkg::RST_ZERO;
      fn_high_q      <= sync_ts_pkg::RST_ZERO;
      lmfc_off_q     <= sync_ts_pkg::RST_ZERO;
      cs_q           <= sync_ts_pkg::RST_ZERO;
      subclass_q     <= sync_ts_pkg::RST_SUBCLASS;
      reg_rdata_o    <= 8'h00;
    end
    else
    begin
      capture_ctrl_q <= capture_ctrl_d;
      ts_delay_q     <= ts_delay_d;
      monitor_q      <= monitor_d;
      chip_sync_q    <= chip_sync_d;
      fn_low_q       <= fn_low_d;
      fn_high_q      <= fn_high_d;
      lmfc_off_q     <= lmfc_off_d;
      cs_q           <= cs_d;
      subclass_q     <= subclass_d;
      reg_rdata_o    <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sysref capture: optional falling-edge front stage, then three flops
  logic neg_q;
  logic s1_q, s2_q, s3_q, level_q;
  logic s1_d, level_d;
  logic edge_sel, trans_sel, armed, subclass1, ts_mode;

  assign edge_sel  = capture_ctrl_q[sync_ts_pkg::EDGE_SEL_BIT];
  assign trans_sel = capture_ctrl_q[sync_ts_pkg::TRANS_SEL_BIT];
  assign armed     = (capture_ctrl_q[sync_ts_pkg::MODE_LSB +: 2] == sync_ts_pkg::MODE_CONTINUOUS)
                  || (capture_ctrl_q[sync_ts_pkg::MODE_LSB +: 2] == sync_ts_pkg::MODE_NSHOT);
  assign subclass1 = subclass_q[sync_ts_pkg::SUBCLASS_BIT];
  assign ts_mode   = chip_sync_q[sync_ts_pkg::SYNC_MODE_BIT];

  // falling clock edge sample of the pin
  always_ff @(negedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      neg_q <= 1'b0;
    end
    else
    begin
      neg_q <= sysref_i;
    end
  end

  // choose capture edge ahead of the first stage, accept level on agreement
  always_comb
  begin
    s1_d    = edge_sel ? neg_q : sysref_i;
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  // synchroniser flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q    <= s1_d;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  // qualifying transition while armed
  assign event_w = armed && (trans_sel ? (level_q && !level_d) : (!level_q && level_d));

  ////////////////////////////////////////////////////////////////////////////
  // lmfc and divider alignment
  logic [5:0]       frame_cnt_q, frame_cnt_d;
  logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
  logic [5:0]       off_frames, off_wrap;
  logic             realign_d, lmfc_d, div_sync_d;

  // offset counts scaled by octets per frame
  always_comb
  begin
    if (octets_per_frame_i == sync_ts_pkg::F_ONE)
    begin
      off_frames = {3'h0, lmfc_off_q[4:2]};
    end
    else if (octets_per_frame_i == sync_ts_pkg::F_TWO)
    begin
      off_frames = {2'h0, lmfc_off_q[4:1]};
    end
    else
    begin
      off_frames = {1'h0, lmfc_off_q[4:0]};
    end
    off_wrap = (frames_per_multi_i == 6'h00) ? off_frames
                                             : off_frames % frames_per_multi_i;
  end

  // counters restart on a subclass 1 event in normal mode only
  always_comb
  begin
    realign_d   = event_w && subclass1 && !ts_mode;
    frame_cnt_d = (frame_cnt_q + 6'h01 >= frames_per_multi_i) ? 6'h00 : frame_cnt_q + 6'h01;
    div_cnt_d   = (div_cnt_q == DIV_W'(DIV_RATIO - 1)) ? '0 : div_cnt_q + DIV_W'(1);
    if (realign_d)
    begin
      frame_cnt_d = 6'h00;
      div_cnt_d   = '0;
    end
    lmfc_d     = (frame_cnt_d == off_wrap);
    div_sync_d = (div_cnt_d == '0);
  end

  // alignment state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_cnt_q    <= 6'h00;
      div_cnt_q      <= '0;
      lmfc_o         <= 1'b0;
      divider_sync_o <= 1'b0;
      realign_o      <= 1'b0;
    end
    else
    begin
      frame_cnt_q    <= frame_cnt_d;
      div_cnt_q      <= div_cnt_d;
      lmfc_o         <= lmfc_d;
      divider_sync_o <= div_sync_d;
      realign_o      <= realign_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timestamp flag and its delay line
  logic [sync_ts_pkg::TS_DEPTH-2:0] pipe_q, pipe_d;
  logic                             flag_now, flag_dly;

  // control bit pattern for a flag, allocated from the top bit down
  function automatic logic [2:0] ctrl_bits(input logic [1:0] cs, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic flag);
    logic [2:0] en;
    logic [2:0] bits;
    en      = (cs == 2'h1) ? 3'b100 : (cs == 2'h2) ? 3'b110 : (cs == 2'h3) ? 3'b111 : 3'b000;
    bits[0] = en[0] && (lo[sync_ts_pkg::FN0_LSB +: 3] == sync_ts_pkg::FN_SYSREF) && flag;
    bits[1] = en[1] && (lo[sync_ts_pkg::FN1_LSB +: 3] == sync_ts_pkg::FN_SYSREF) && flag;
    bits[2] = en[2] && (hi[sync_ts_pkg::FN2_LSB +: 3] == sync_ts_pkg::FN_SYSREF) && flag;
    return bits;
  endfunction

  // flag only in timestamp mode and full bandwidth
  always_comb
  begin
    flag_now = event_w && ts_mode && !decimation_on_i;
    pipe_d   = {pipe_q[sync_ts_pkg::TS_DEPTH-3:0], flag_now};
    flag_dly = (ts_delay_q == 8'h00) ? flag_now : pipe_q[ts_delay_q - 8'h01];
  end

  // delay line state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pipe_q <= '0;
    end
    else
    begin
      pipe_q <= pipe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel output words, one stage each so latency matches
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      sync_ts_pkg::sample_word_s word_d;

      // data and control bits of the coincident sample
      always_comb
      begin
        word_d.data = sample_i[ch];
        word_d.ctrl = ctrl_bits(cs_q[sync_ts_pkg::CS_LSB +: 2], fn_low_q, fn_high_q,
                                flag_dly);
      end

      // output word register
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          word_o[ch] <= '0;
        end
        else
        begin
          word_o[ch] <= word_d;
        end
      end
    end
  endgenerate

endmodule

// >>> sync_ts_pkg.sv
// Purpose: shared constants and types for the sysref / lmfc / timestamp block
// Assumes: 8-bit registers on a 12-bit register address; one frame per clock
// Notes:   offsets, field positions and reset values are named here once
// Functional notes
// - one select bit picks subclass 0 or 1; resets to 1, subclass 1
// - subclass 1 sysref event realigns lmfc and the internal sample dividers
// - five-bit lmfc offset delays lmfc phase in whole frame steps
// - one octet per frame: four counts per frame; two octets: two counts
// - any other octets-per-frame value: one frame per offset count
// - transition select chooses rising or falling sysref level change
// - edge select samples sysref on rising or falling clock edge
// - sync mode bit resets to 0, normal mode, sysref resets internal clocks
// - sync mode bit 1 selects timestamp synchronization
// - timestamp mode leaves clocks alone, flags coincident sample in control bits
// - three-bit selector per control bit; code 5 carries timestamp flag
// - control bits allocated from bit 2 downward
// - both channels share identical pipeline latency
// - timestamp delay register shifts which sample carries the flag
// - no timestamping while decimation is in use
// - sysref mode arms capture; 1 continuous, 2 n-shot self-clears on event
// - monitor register: hold status upper nibble, setup status lower nibble
package sync_ts_pkg;

  // register offsets
  localparam logic [11:0] ADDR_CAPTURE_CTRL  = 12'h120;
  localparam logic [11:0] ADDR_TS_DELAY      = 12'h123;
  localparam logic [11:0] ADDR_SH_MONITOR    = 12'h128;
  localparam logic [11:0] ADDR_CHIP_SYNC     = 12'h1ff;
  localparam logic [11:0] ADDR_CTRL_FN_LOW   = 12'h559;
  localparam logic [11:0] ADDR_CTRL_FN_HIGH  = 12'h55a;
  localparam logic [11:0] ADDR_LMFC_OFFSET   = 12'h578;
  localparam logic [11:0] ADDR_CTRL_PER_SMP  = 12'h58f;
  localparam logic [11:0] ADDR_SUBCLASS      = 12'h590;

  // field positions
  localparam int SUBCLASS_BIT     = 5;
  localparam int TRANS_SEL_BIT    = 4;
  localparam int EDGE_SEL_BIT     = 3;
  localparam int MODE_LSB         = 1;
  localparam int SYNC_MODE_BIT    = 0;
  localparam int CS_LSB           = 6;
  localparam int FN0_LSB          = 0;
  localparam int FN1_LSB          = 4;
  localparam int FN2_LSB          = 0;
  localparam int HOLD_LSB         = 4;
  localparam int SETUP_LSB        = 0;

  // reset values
  localparam logic [7:0] RST_SUBCLASS   = 8'h20;
  localparam logic [7:0] RST_CHIP_SYNC  = 8'h00;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // field codes
  localparam logic [1:0] MODE_OFF        = 2'h0;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
  localparam logic [1:0] MODE_NSHOT      = 2'h2;
  localparam logic [2:0] FN_SYSREF       = 3'h5;
  localparam logic [7:0] F_ONE           = 8'h01;
  localparam logic [7:0] F_TWO           = 8'h02;

  // sample path
  localparam int SAMPLE_W = 14;
  localparam int CTRL_W   = 3;
  localparam int TS_DEPTH = 256;

  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic [CTRL_W-1:0]   ctrl;
  } sample_word_s;

endpackage

// >>> sync_ts_asserts.sv
// Purpose: port-level assertions for the sysref, lmfc and timestamp block
// Assumes: registers change only through the write strobe port
// Notes:   shadows keep the few register fields the checks need
`timescale 1ns/100ps
module sync_ts_asserts #(
  parameter int DIV_RATIO = 4
) (
  // clock and reset
  input wire logic                                  clk_i,
  input wire logic                                  rst_n_i,
  // register writes and configuration
  input wire logic [11:0]                           reg_addr_i,
  input wire logic [7:0]                            reg_wdata_i,
  input wire logic                                  reg_wr_i,
  input wire logic [7:0]                            octets_per_frame_i,
  input wire logic [5:0]                            frames_per_multi_i,
  // samples and outputs
  input wire logic [1:0][sync_ts_pkg::SAMPLE_W-1:0] sample_i,
  input wire sync_ts_pkg::sample_word_s [1:0]       word_o,
  input wire logic                                  lmfc_o,
  input wire logic                                  divider_sync_o,
  input wire logic                                  realign_o
);
  logic       sub_q, sub_d, ts_q, ts_d, zero_off;
  logic [1:0] cs_q, cs_d;
  logic [4:0] off_q, off_d;
  logic [5:0] off_fr;
  logic [7:0] gap_q, gap_d;
  // shadow written fields, count clocks since the last divider sync
  always_comb
  begin
    sub_d = sub_q;
    ts_d  = ts_q;
    cs_d  = cs_q;
    off_d = off_q;
    gap_d = divider_sync_o ? 8'h00 : gap_q + 8'h01;
    if (reg_wr_i && reg_addr_i == 12'h590) sub_d = reg_wdata_i[5];
    if (reg_wr_i && reg_addr_i == 12'h1ff) ts_d = reg_wdata_i[0];
    if (reg_wr_i && reg_addr_i == 12'h58f) cs_d = reg_wdata_i[7:6];
    if (reg_wr_i && reg_addr_i == 12'h578) off_d = reg_wdata_i[4:0];
  end
  // register the shadows
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub_q <= 1'b1;
      ts_q  <= 1'b0;
      cs_q  <= 2'h0;
      off_q <= 5'h00;
      gap_q <= 8'h00;
    end
    else
    begin
      sub_q <= sub_d;
      ts_q  <= ts_d;
      cs_q  <= cs_d;
      off_q <= off_d;
      gap_q <= gap_d;
    end
  end
  // offset that lands on frame zero after scaling by octets per frame
  assign off_fr   = (octets_per_frame_i == 8'h01) ? {3'h0, off_q[4:2]} :
                    (octets_per_frame_i == 8'h02) ? {2'h0, off_q[4:1]} : {1'h0, off_q};
  // a whole number of multiframes of delay lands on frame zero again
  assign zero_off = (frames_per_multi_i != 6'h00) ? ((off_fr % frames_per_multi_i) == 6'h00)
                                                  : (off_fr == 6'h00);
////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_realign_pulse; realign_o |=> !realign_o; endproperty
  a_realign_pulse: assert property (p_realign_pulse)
    else $error("realign wider than one cycle");
  property p_realign_div; realign_o |-> divider_sync_o; endproperty
  a_realign_div: assert property (p_realign_div)
    else $error("divider not at phase zero on realign");
  property p_realign_mode; realign_o |-> sub_q && !ts_q; endproperty
  a_realign_mode: assert property (p_realign_mode)
    else $error("realign outside subclass one normal mode");
  property p_realign_lmfc; realign_o |-> lmfc_o == zero_off; endproperty
  a_realign_lmfc: assert property (p_realign_lmfc)
    else $error("lmfc phase after realign wrong");
  property p_div_gap; gap_q <= 8'(DIV_RATIO); endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("divider sync missing");
  property p_word_data;
    $past(rst_n_i) |-> word_o[0].data == $past(sample_i[0]) && word_o[1].data == $past(sample_i[1]);
  endproperty
  a_word_data: assert property (p_word_data)
    else $error("sample path latency wrong");
  property p_chan_match; word_o[0].ctrl == word_o[1].ctrl; endproperty
  a_chan_match: assert property (p_chan_match)
    else $error("channels carry different control bits");
  property p_ctrl_alloc;
    word_o[0].ctrl != 3'h0 |-> cs_q != 2'h0 && (!word_o[0].ctrl[0] || cs_q == 2'h3)
      && (!word_o[0].ctrl[1] || cs_q >= 2'h2);
  endproperty
  a_ctrl_alloc: assert property (p_ctrl_alloc)
    else $error("control bit outside allocation");
  property p_ctrl_mode; word_o[0].ctrl != 3'h0 |-> ts_q; endproperty
  a_ctrl_mode: assert property (p_ctrl_mode)
    else $error("stamp outside timestamp mode");
endmodule
bind sync_ts sync_ts_asserts #(.DIV_RATIO(DIV_RATIO)) i_sync_ts_asserts (
  .clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .octets_per_frame_i,
  .frames_per_multi_i,
  .sample_i, .word_o, .lmfc_o, .divider_sync_o, .realign_o);

// >>> jesd_rx_model.sv
// Purpose: far end: sysref source and stamp-aware receiver
// Assumes: one word per clock on each channel
// Notes:   sysref pulses last four clocks, above the two-clock minimum, and
//          leave on the falling clock edge so the capture edge select shows
`timescale 1ns/100ps
module jesd_rx_model (
  // clock and reset
  input wire logic                            clk_i,
  input wire logic                            rst_n_i,
  // pulse request and incoming words
  input wire logic                            fire_i,
  input wire sync_ts_pkg::sample_word_s [1:0] word_i,
  // sysref and stamp record
  output logic                                sysref_o,
  output logic [7:0]                          stamps_o,
  output logic [2:0]                          last_ctrl_o,
  output logic [13:0]                         last_data_o
);
  logic [2:0] hold_q;
  logic       pulse_q;
  // shape sysref, record each stamped word
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_q      <= 3'h0;
      pulse_q     <= 1'b0;
      stamps_o    <= 8'h00;
      last_ctrl_o <= 3'h0;
      last_data_o <= 14'h0000;
    end
    else
    begin
      hold_q   <= fire_i ? 3'h4 : hold_q - {2'h0, hold_q != 3'h0};
      pulse_q  <= fire_i || hold_q > 3'h1;
      if (word_i[0].ctrl != 3'h0)
      begin
        stamps_o    <= stamps_o + 8'h01;
        last_ctrl_o <= word_i[0].ctrl;
        last_data_o <= word_i[0].data;
      end
    end
  end
  // launch sysref half a clock late, one cycle apart between capture edges
  always_ff @(negedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sysref_o <= 1'b0;
    end
    else
    begin
      sysref_o <= pulse_q;
    end
  end
endmodule

// >>> sync_ts_bench.sv
// Purpose: self-checking bench for the sysref, lmfc and timestamp block
// Assumes: inputs change on the falling clock edge
// Notes:   K fixed at eight frames, divider ratio four
`timescale 1ns/100ps
module sync_ts_bench;
  typedef struct packed {logic [11:0] a; logic [7:0] d, r, e;} row_s;
  typedef struct packed {logic [7:0] c, f; logic [4:0] o; logic [2:0] n; logic [3:0] l;} al_s;
  logic                            clk_i = 1'b0, rst_n_i = 1'b0;
  logic                            wr_i = 1'b0, fire = 1'b0, dec = 1'b0;
  logic                            lmfc, dsync, realign, sysref;
  logic [11:0]                     addr = 12'h000;
  logic [7:0]                      wdata = 8'h00, octets = 8'h04, rdata, stamps, s;
  logic [13:0]                     cnt = 14'h0000, t0, d0, ldata;
  logic [1:0][13:0]                samp;
  logic [2:0]                      lctrl;
  sync_ts_pkg::sample_word_s [1:0] word;
  int                              mismatches = 0, tests_run = 0, nre = 0, b, n;
  row_s rows[10] = '{'{12'h590, 8'h1f, 8'h20, 8'h1f}, '{12'h120, 8'ha5, 8'h00, 8'ha5},
    '{12'h123, 8'h5a, 8'h00, 8'h5a}, '{12'h128, 8'hff, 8'h00, 8'h00},
    '{12'h1ff, 8'h01, 8'h00, 8'h01}, '{12'h559, 8'h55, 8'h00, 8'h55},
    '{12'h55a, 8'h05, 8'h00, 8'h05}, '{12'h578, 8'h1f, 8'h00, 8'h1f},
    '{12'h58f, 8'hc0, 8'h00, 8'hc0}, '{12'h7ff, 8'hff, 8'h00, 8'h00}};
  al_s als[4] = '{'{8'h02, 8'h04, 5'h00, 3'h0, 4'h4}, '{8'h0a, 8'h01, 5'h06, 3'h1, 4'h5},
    '{8'h12, 8'h02, 5'h05, 3'h2, 4'h8}, '{8'h1a, 8'h04, 5'h03, 3'h3, 4'h9}};
  // clock, sample ramp and realign count
  always #2 clk_i = ~clk_i;
  always @(negedge clk_i) cnt <= cnt + 14'h0001;
  always @(negedge clk_i) if (realign === 1'b1) nre++;
  assign samp[0] = cnt;
  assign samp[1] = ~cnt;
  sync_ts #(.DIV_RATIO(4), .DIV_W(3)) i_sync_ts (
    .clk_i, .rst_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_i),
    .reg_rdata_o(rdata), .sysref_i(sysref), .octets_per_frame_i(octets),
    .frames_per_multi_i(6'h08), .decimation_on_i(dec), .setup_status_i(4'h3),
    .hold_status_i(4'h8), .sample_i(samp), .word_o(word), .lmfc_o(lmfc),
    .divider_sync_o(dsync), .realign_o(realign));
  jesd_rx_model i_jesd_rx_model (
    .clk_i, .rst_n_i, .fire_i(fire), .word_i(word), .sysref_o(sysref),
    .stamps_o(stamps), .last_ctrl_o(lctrl), .last_data_o(ldata));
////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_i);
    addr = a;
    @(negedge clk_i);
    check({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic pulse(input int w);
    @(negedge clk_i);
    fire = 1'b1;
    t0 = cnt;
    @(negedge clk_i);
    fire = 1'b0;
    repeat (w) @(negedge clk_i);
  endtask
  // bounded wait for realign or lmfc, counting clocks
  task automatic wait_for(input logic lm, output int k);
    k = 0;
    while ((lm ? lmfc : realign) !== 1'b1)
    begin
      @(negedge clk_i);
      k++;
      if (k == 40)
      begin
        mismatches++;
        summarize();
      end
    end
  endtask
////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a, rows[i].r);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
      wr(rows[i].a, rows[i].r);
    end
    foreach (als[i])
    begin
      octets = als[i].f;
      wr(12'h120, als[i].c);
      wr(12'h578, {3'h0, als[i].o});
      pulse(0);
      wait_for(1'b0, n);
      check(16'(n), {12'h000, als[i].l});
      wait_for(1'b1, n);
      check(16'(n), {13'h0000, als[i].n});
    end
    rd(12'h128, 8'h83);
    wr(12'h120, 8'h04);
    b = nre;
    pulse(20);
    rd(12'h120, 8'h00);
    pulse(20);
    check(16'(nre - b), 16'h0001);
    wr(12'h590, 8'h00);
    wr(12'h120, 8'h02);
    b = nre;
    pulse(20);
    check(16'(nre - b), 16'h0000);
    wr(12'h590, 8'h20);
    wr(12'h1ff, 8'h01);
    wr(12'h58f, 8'h40);
    wr(12'h55a, 8'h05);
    s = stamps;
    pulse(20);
    check(16'(nre - b), 16'h0000);
    check({8'h00, stamps - s}, 16'h0001);
    check({13'h0000, lctrl}, 16'h0004);
    d0 = ldata - t0;
    wr(12'h123, 8'h05);
    pulse(20);
    check({2'h0, 14'(ldata - t0 - d0)}, 16'h0005);
    wr(12'h123, 8'h00);
    wr(12'h58f, 8'h80);
    wr(12'h55a, 8'h00);
    wr(12'h559, 8'h50);
    pulse(20);
    check({13'h0000, lctrl}, 16'h0002);
    dec = 1'b1;
    s = stamps;
    pulse(20);
    check({8'h00, stamps - s}, 16'h0000);
    summarize();
  end
endmodule
